// File: logic/pmc_top.sv
// Power mode controller: clock selection, low-power entry and wake-up.
// Overview of operation
// - Control bit 7 keeps system clock running in idle when set.
// - Two-bit select picks fast oscillator: 8, 16, 12 or 8 MHz.
// - Control bits 6 and 3 always read zero.
// - Brownout flag set by low-voltage reset, cleared by power-up or software zero.
// - Bad threshold register value resets and sets fault flag bit 1.
// - Bad watchdog configuration sets fault flag bit 0; software clears.
// - Fast select 0 with divider 000 or 001 selects slow sub-clock.
// - Fast select 1 or divider 010 to 111 uses fast oscillator.
// - Slow mode stops fast oscillator and its divided clocks.
// - Slow oscillator stable bit is readable by software.
// - Fast oscillator stable bit is readable by software.
// - Power-down with idle select 0 enters sleep.
// - Idle select 1 and keep bit 0 enters idle with clock off.
// - Idle select 1 and keep bit 1 enters idle with clock on.
// - Low-power entry holds state and clears watchdog counter.
// - Power-down entry sets power-down flag, clears watchdog expiry flag.
// - Wake on Port A falling edge, interrupt or watchdog overflow.
// - Watchdog overflow in low power sets expiry flag, partial reset.
// - Power-down flag cleared by power-up or clear-watchdog instruction.
// - Each Port A pin has a wake enable; wake resumes after halt.
// - Enabled interrupt with stack room is serviced; else resume after halt.
// - Interrupt pending before entry cannot wake the device.
`timescale 1ns/1ps
`default_nettype none
module pmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic clrwdt_exec,
  input wire logic wdt_overflow,
  input wire logic lvr_event,
  input wire logic lv_config_bad,
  input wire logic wdt_config_bad,
  input wire logic slow_osc_ready,
  input wire logic fast_osc_ready,
  input wire logic [7:0] porta_in,
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  output logic fast_osc_enable,
  output logic [4:0] fast_osc_mhz,
  output logic sysclk_from_slow,
  output logic sysclk_run,
  output logic timebase_run,
  output logic cpu_halted,
  output logic wdt_clear,
  output logic partial_reset,
  output logic soft_reset,
  output logic irq_service
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] wake_en;
    logic powerdown_flag;
    logic to;
    pmc_pkg::pmc_state_t st;
    pmc_pkg::pmc_wake_t cause;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic fosc_en;
    logic [4:0] mhz;
    logic slow;
    logic sys_run;
    logic tb_run;
    logic halted;
    logic wclr;
    logic prst;
    logic srst;
    logic isvc;
  } pmc_st_t;

  pmc_st_t s_r, s_nxt;
  pmc_wake_if wk ();

  function automatic logic [4:0] freq_of(input logic [1:0] sel);
    case (sel)
      2'b01: freq_of = pmc_pkg::PMC_FREQ_16;
      2'b10: freq_of = pmc_pkg::PMC_FREQ_12;
      default: freq_of = pmc_pkg::PMC_FREQ_8;
    endcase
  endfunction

  function automatic logic is_slow(input logic [7:0] m);
    is_slow = !m[pmc_pkg::PMC_MODE_FAST] &&
              (m[pmc_pkg::PMC_MODE_DIV_LO +: 3] <= pmc_pkg::PMC_DIV_SLOW_MAX);
  endfunction

  pmc_wake_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .porta_in(porta_in),
    .porta_wake_enable(s_r.wake_en),
    .irq_req(irq_req),
    .wk(wk.det)
  );

  logic wr_commit;
  logic acc;
  logic [7:0] wb;
  logic wake_port;
  logic wake_irq;
  logic [7:0] irq_hit;
  logic low_power;

  assign acc = psel && !penable;
  // Writes commit only at the edge that completes the access phase.
  assign wr_commit = psel && penable && pwrite && s_r.ready;
  assign wb = pwdata[7:0];
  assign low_power = (s_r.st != pmc_pkg::PMC_RUN);
  assign wk.arm = low_power;
  assign wake_port = |wk.pin_fall;
  assign irq_hit = wk.irq_ok;
  assign wake_irq = |irq_hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.wclr = 1'b0;
    s_nxt.prst = 1'b0;
    s_nxt.srst = 1'b0;
    s_nxt.isvc = 1'b0;
    // Ready is raised in the setup cycle so every access takes one wait-free phase.
    s_nxt.ready = acc;
    s_nxt.err = 1'b0;
    if (acc && !pwrite) begin
      case (paddr)
        pmc_pkg::PMC_OFS_CTRL: s_nxt.rdata = {24'h000000,
                                 s_r.ctrl & pmc_pkg::PMC_CTRL_WMASK};
        pmc_pkg::PMC_OFS_MODE: s_nxt.rdata = {24'h000000, s_r.mode};
        pmc_pkg::PMC_OFS_STAT: s_nxt.rdata = {24'h000000, s_r.cause, s_r.st,
                                 fast_osc_ready, slow_osc_ready, s_r.to, s_r.powerdown_flag};
        pmc_pkg::PMC_OFS_WAKE: s_nxt.rdata = {24'h000000, s_r.wake_en};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.err = 1'b1;
        end
      endcase
    end else if (acc) begin
      s_nxt.rdata = 32'h00000000;
      // The error answer is prepared in setup so that it stands together with pready.
      case (paddr)
        pmc_pkg::PMC_OFS_CTRL, pmc_pkg::PMC_OFS_MODE, pmc_pkg::PMC_OFS_WAKE,
        pmc_pkg::PMC_OFS_STAT: s_nxt.err = 1'b0;
        default: s_nxt.err = 1'b1;
      endcase
    end
    if (wr_commit) begin
      case (paddr)
        pmc_pkg::PMC_OFS_CTRL: begin
          s_nxt.ctrl[7:3] = wb[7:3] & pmc_pkg::PMC_CTRL_WMASK[7:3];
          // Flags accept only a written zero.
          s_nxt.ctrl[2:0] = s_r.ctrl[2:0] & wb[2:0];
        end
        pmc_pkg::PMC_OFS_MODE: s_nxt.mode = wb;
        pmc_pkg::PMC_OFS_WAKE: s_nxt.wake_en = wb;
        default: s_nxt.wake_en = s_r.wake_en;
      endcase
    end
    // Hardware sets win over a software clear in the same cycle.
    if (lvr_event) begin
      s_nxt.ctrl[pmc_pkg::PMC_CTRL_BOR] = 1'b1;
    end
    if (lv_config_bad) begin
      s_nxt.ctrl[pmc_pkg::PMC_CTRL_LVF] = 1'b1;
      s_nxt.srst = 1'b1;
    end
    if (wdt_config_bad) begin
      s_nxt.ctrl[pmc_pkg::PMC_CTRL_WDF] = 1'b1;
      s_nxt.srst = 1'b1;
    end
    if (clrwdt_exec) begin
      s_nxt.powerdown_flag = 1'b0;
    end
    case (s_r.st)
      pmc_pkg::PMC_RUN: begin
        if (halt_exec) begin
          s_nxt.powerdown_flag = 1'b1;
          s_nxt.to = 1'b0;
          s_nxt.wclr = 1'b1;
          s_nxt.cause = pmc_pkg::PMC_WK_NONE;
          if (!s_r.mode[pmc_pkg::PMC_MODE_IDLE]) begin
            s_nxt.st = pmc_pkg::PMC_SLEEP;
          end else if (!s_r.ctrl[pmc_pkg::PMC_CTRL_KEEP]) begin
            s_nxt.st = pmc_pkg::PMC_IDLE_OFF;
          end else begin
            s_nxt.st = pmc_pkg::PMC_IDLE_ON;
          end
        end
      end
      pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_IDLE_OFF, pmc_pkg::PMC_IDLE_ON: begin
        // Watchdog wake has priority; it restarts only program counter and stack.
        if (wdt_overflow) begin
          s_nxt.st = pmc_pkg::PMC_RUN;
          s_nxt.to = 1'b1;
          s_nxt.prst = 1'b1;
          s_nxt.cause = pmc_pkg::PMC_WK_WDT;
        end else if (wake_port) begin
          s_nxt.st = pmc_pkg::PMC_RUN;
          s_nxt.cause = pmc_pkg::PMC_WK_PORT;
        end else if (wake_irq) begin
          s_nxt.st = pmc_pkg::PMC_RUN;
          s_nxt.cause = pmc_pkg::PMC_WK_IRQ;
          s_nxt.isvc = |(irq_hit & irq_enable) && !stack_full;
        end
      end
      default: s_nxt.st = pmc_pkg::PMC_RUN;
    endcase
    // Clock outputs follow the next state so they match the registered mode.
    s_nxt.slow = is_slow(s_nxt.mode);
    s_nxt.mhz = freq_of(s_nxt.ctrl[pmc_pkg::PMC_CTRL_FSEL_LO +: 2]);
    s_nxt.sys_run = (s_nxt.st == pmc_pkg::PMC_RUN) ||
                    (s_nxt.st == pmc_pkg::PMC_IDLE_ON);
    s_nxt.tb_run = (s_nxt.st != pmc_pkg::PMC_SLEEP);
    s_nxt.halted = (s_nxt.st != pmc_pkg::PMC_RUN);
    // The fast oscillator runs only while something uses it.
    s_nxt.fosc_en = !s_nxt.slow && s_nxt.sys_run;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= pmc_pkg::PMC_CTRL_RST;
      s_r.mode <= pmc_pkg::PMC_MODE_RST;
      s_r.mhz <= pmc_pkg::PMC_FREQ_8;
      s_r.fosc_en <= 1'b1;
      s_r.sys_run <= 1'b1;
      s_r.tb_run <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign fast_osc_enable = s_r.fosc_en;
  assign fast_osc_mhz = s_r.mhz;
  assign sysclk_from_slow = s_r.slow;
  assign sysclk_run = s_r.sys_run;
  assign timebase_run = s_r.tb_run;
  assign cpu_halted = s_r.halted;
  assign wdt_clear = s_r.wclr;
  assign partial_reset = s_r.prst;
  assign soft_reset = s_r.srst;
  assign irq_service = s_r.isvc;

  ////////////////////////////////////////////////////////////////////////////
  property p_halt_flags;
    @(posedge pclk) disable iff (!presetn)
    (s_r.st == pmc_pkg::PMC_RUN && halt_exec && !clrwdt_exec) |=> (s_r.powerdown_flag && !s_r.to && wdt_clear);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
    (s_r.st == pmc_pkg::PMC_RUN && halt_exec && !s_r.mode[pmc_pkg::PMC_MODE_IDLE])
      |=> (!sysclk_run && !timebase_run && cpu_halted);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_idle_keep;
    @(posedge pclk) disable iff (!presetn)
    (s_r.st == pmc_pkg::PMC_RUN && halt_exec && s_r.mode[pmc_pkg::PMC_MODE_IDLE])
      |=> (sysclk_run == $past(s_r.ctrl[pmc_pkg::PMC_CTRL_KEEP])) && timebase_run;
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("idle clock wrong");

  property p_bor_sticky;
    @(posedge pclk) disable iff (!presetn)
    lvr_event |=> s_r.ctrl[pmc_pkg::PMC_CTRL_BOR];
  endproperty
  a_bor_sticky: assert property (p_bor_sticky) else $error("brownout flag lost");

  property p_wdf_set;
    @(posedge pclk) disable iff (!presetn)
    wdt_config_bad |=> (s_r.ctrl[pmc_pkg::PMC_CTRL_WDF] && soft_reset);
  endproperty
  a_wdf_set: assert property (p_wdf_set) else $error("watchdog fault flag");

  property p_slow_sel;
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && paddr == pmc_pkg::PMC_OFS_MODE && !pwdata[pmc_pkg::PMC_MODE_FAST] &&
     pwdata[pmc_pkg::PMC_MODE_DIV_LO +: 3] <= pmc_pkg::PMC_DIV_SLOW_MAX)
      |=> sysclk_from_slow;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("clock source wrong");

  property p_fast_stop;
    @(posedge pclk) disable iff (!presetn)
    sysclk_from_slow |-> !fast_osc_enable;
  endproperty
  a_fast_stop: assert property (p_fast_stop) else $error("fast osc not stopped");

  sequence s_wdt_wake;
    low_power && wdt_overflow;
  endsequence
  property p_wdt_wake;
    @(posedge pclk) disable iff (!presetn)
    s_wdt_wake |=> (partial_reset && s_r.to && !cpu_halted);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_port_wake;
    @(posedge pclk) disable iff (!presetn)
    (low_power && wake_port) |=> !cpu_halted;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("port wake missed");

  property p_ctrl_rsv;
    @(posedge pclk) disable iff (!presetn)
    (pready && paddr == pmc_pkg::PMC_OFS_CTRL && !pwrite) |-> (prdata[6] == 1'b0 && prdata[3] == 1'b0);
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bits nonzero");

  property p_fast_sel;
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && paddr == pmc_pkg::PMC_OFS_MODE && (pwdata[pmc_pkg::PMC_MODE_FAST] ||
     pwdata[pmc_pkg::PMC_MODE_DIV_LO +: 3] > pmc_pkg::PMC_DIV_SLOW_MAX))
      |=> !sysclk_from_slow;
  endproperty
  a_fast_sel: assert property (p_fast_sel) else $error("fast clock not restored");

  property p_idle_on;
    @(posedge pclk) disable iff (!presetn)
    (s_r.st == pmc_pkg::PMC_RUN && halt_exec && s_r.mode[pmc_pkg::PMC_MODE_IDLE] &&
     s_r.ctrl[pmc_pkg::PMC_CTRL_KEEP]) |=> (cpu_halted && sysclk_run);
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("idle with clock on wrong");

  property p_pdf_clr;
    @(posedge pclk) disable iff (!presetn)
    (clrwdt_exec && !(s_r.st == pmc_pkg::PMC_RUN && halt_exec)) |=> !s_r.powerdown_flag;
  endproperty
  a_pdf_clr: assert property (p_pdf_clr) else $error("power-down flag not cleared");

  sequence s_irq_only_wake;
    low_power && !wdt_overflow && !wake_port && wake_irq;
  endsequence
  property p_irq_held;
    @(posedge pclk) disable iff (!presetn)
    (s_irq_only_wake and stack_full) |=> (!cpu_halted && !irq_service);
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("interrupt served with full stack");
endmodule
`default_nettype wire

// File: logic/pmc_pkg.sv
// Package of constants and types for the power mode controller.
package pmc_pkg;
  localparam int unsigned PMC_ADDR_W = 4;
  localparam logic [3:0] PMC_OFS_CTRL = 4'h0;
  localparam logic [3:0] PMC_OFS_MODE = 4'h4;
  localparam logic [3:0] PMC_OFS_STAT = 4'h8;
  localparam logic [3:0] PMC_OFS_WAKE = 4'hc;
  // Control register field positions.
  localparam int unsigned PMC_CTRL_KEEP = 7;
  localparam int unsigned PMC_CTRL_FSEL_LO = 4;
  localparam int unsigned PMC_CTRL_BOR = 2;
  localparam int unsigned PMC_CTRL_LVF = 1;
  localparam int unsigned PMC_CTRL_WDF = 0;
  localparam logic [7:0] PMC_CTRL_WMASK = 8'hb7;
  localparam logic [7:0] PMC_CTRL_RST = 8'h00;
  // Mode register field positions.
  localparam int unsigned PMC_MODE_FAST = 0;
  localparam int unsigned PMC_MODE_IDLE = 1;
  localparam int unsigned PMC_MODE_DIV_LO = 5;
  localparam logic [7:0] PMC_MODE_RST = 8'h01;
  // Status register field positions.
  localparam int unsigned PMC_STAT_PDF = 0;
  localparam int unsigned PMC_STAT_TO = 1;
  localparam int unsigned PMC_STAT_LSTB = 2;
  localparam int unsigned PMC_STAT_HSTB = 3;
  localparam int unsigned PMC_STAT_STATE_LO = 4;
  localparam logic [2:0] PMC_DIV_SLOW_MAX = 3'h1;
  localparam int unsigned PMC_PORTA_W = 8;
  // Fast oscillator frequency in MHz.
  localparam logic [4:0] PMC_FREQ_8 = 5'h08;
  localparam logic [4:0] PMC_FREQ_12 = 5'h0c;
  localparam logic [4:0] PMC_FREQ_16 = 5'h10;
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_SLEEP = 2'b01,
    PMC_IDLE_OFF = 2'b10,
    PMC_IDLE_ON = 2'b11
  } pmc_state_t;
  typedef enum logic [1:0] {
    PMC_WK_NONE = 2'b00,
    PMC_WK_PORT = 2'b01,
    PMC_WK_IRQ = 2'b10,
    PMC_WK_WDT = 2'b11
  } pmc_wake_t;
endpackage

// File: logic/pmc_wake_if.sv
// Interface between the controller and its wake detector.
`timescale 1ns/1ps
`default_nettype none
interface pmc_wake_if;
  logic arm;
  logic [7:0] pin_fall;
  logic [7:0] irq_ok;
  modport det (input arm, output pin_fall, output irq_ok);
  modport ctl (output arm, input pin_fall, input irq_ok);
endinterface
`default_nettype wire

// File: logic/pmc_wake_det.sv
// Port A falling edge detector and interrupt pre-pend mask.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] porta_in,
  input wire logic [7:0] porta_wake_enable,
  input wire logic [7:0] irq_req,
  pmc_wake_if.det wk
);
  typedef struct packed {
    logic [7:0] prev;
    logic arm_d;
    logic [7:0] pend_mask;
  } pmc_wd_st_t;
  pmc_wd_st_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = porta_in;
    s_nxt.arm_d = wk.arm;
    // Requests already standing when the low-power mode starts are masked.
    if (wk.arm && !s_r.arm_d) begin
      s_nxt.pend_mask = irq_req;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign wk.pin_fall = s_r.prev & ~porta_in & porta_wake_enable;
  assign wk.irq_ok = irq_req & ~s_r.pend_mask & {8{s_r.arm_d}};
endmodule
`default_nettype wire

// File: verification/power_mode_controller_test.sv
// Self-checking bench for the power mode controller, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
  localparam logic [3:0] A_CTL = pmc_pkg::PMC_OFS_CTRL;
  localparam logic [3:0] A_MOD = pmc_pkg::PMC_OFS_MODE;
  localparam logic [3:0] A_STA = pmc_pkg::PMC_OFS_STAT;
  localparam logic [3:0] A_WAK = pmc_pkg::PMC_OFS_WAKE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic halt_exec, clrwdt_exec, wdt_overflow, lvr_event, lv_config_bad, wdt_config_bad;
  logic slow_osc_ready, fast_osc_ready, stack_full;
  logic [7:0] porta_in, irq_req, irq_enable;
  logic fast_osc_enable, sysclk_from_slow, sysclk_run, timebase_run, cpu_halted;
  logic wdt_clear, partial_reset, soft_reset, irq_service;
  logic [4:0] fast_osc_mhz;
  logic [4:0] mhz_exp [4];
  int num_errors, cmp_count, n_wclr, n_prst, n_srst, n_irq, n0;
  logic slow;
  pmc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .halt_exec, .clrwdt_exec, .wdt_overflow, .lvr_event, .lv_config_bad,
    .wdt_config_bad, .slow_osc_ready, .fast_osc_ready, .porta_in, .irq_req, .irq_enable,
    .stack_full, .fast_osc_enable, .fast_osc_mhz, .sysclk_from_slow, .sysclk_run,
    .timebase_run, .cpu_halted, .wdt_clear, .partial_reset, .soft_reset, .irq_service);
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  // Pulses are counted rather than caught at one edge, so checks do not hinge on latency.
  always @(posedge pclk) begin
    if (wdt_clear === 1'h1) n_wclr++;
    if (partial_reset === 1'h1) n_prst++;
    if (soft_reset === 1'h1) n_srst++;
    if (irq_service === 1'h1) n_irq++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    chk({31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic halt();
    halt_exec <= 1'h1;
    step(1);
    halt_exec <= 1'h0;
    step(3);
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 4000);
    num_errors++;
    print_verdict();
  end
  initial begin
    mhz_exp = '{pmc_pkg::PMC_FREQ_8, pmc_pkg::PMC_FREQ_16, pmc_pkg::PMC_FREQ_12,
      pmc_pkg::PMC_FREQ_8};
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {halt_exec, clrwdt_exec, wdt_overflow, lvr_event, lv_config_bad, wdt_config_bad} = '0;
    {fast_osc_ready, stack_full, irq_req, irq_enable} = '0;
    slow_osc_ready = 1'h1;
    porta_in = 8'hff;
    step(8);
    presetn <= 1'h1;
    rd(A_CTL, 32'hffffffff, 32'h0);
    rd(A_MOD, 32'hffffffff, 32'h01);
    rd(A_STA, 32'hffffffff, 32'h04);
    chk({27'h0, fast_osc_mhz}, 32'h08);
    fast_osc_ready <= 1'h1;
    rd(A_STA, 32'hff, 32'h0c);
    apb(1'h0, 4'h2, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    end_test("reset");
    wr(A_CTL, 32'hff);
    rd(A_CTL, 32'hffffffff, 32'hb0);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, {24'h0, 2'h0, k[1:0], 4'h0});
      step(2);
      chk({27'h0, fast_osc_mhz}, {27'h0, mhz_exp[k]});
    end
    lvr_event <= 1'h1;
    lv_config_bad <= 1'h1;
    wdt_config_bad <= 1'h1;
    step(1);
    {lvr_event, lv_config_bad, wdt_config_bad} <= 3'h0;
    step(2);
    rd(A_CTL, 32'hff, 32'h37);
    chk({31'h0, n_srst > 0}, 32'h1);
    wr(A_CTL, 32'h06);
    rd(A_CTL, 32'hff, 32'h06);
    wr(A_CTL, 32'h0);
    rd(A_CTL, 32'hff, 32'h0);
    end_test("control");
    // Index 8 is the fast select bit set with the slowest divider code.
    for (int k = 0; k < 9; k++) begin
      wr(A_MOD, (k < 8) ? {24'h0, k[2:0], 5'h0} : 32'h01);
      step(2);
      slow = (k < 2);
      chk({31'h0, sysclk_from_slow}, {31'h0, slow});
      chk({31'h0, fast_osc_enable}, {31'h0, !slow});
    end
    end_test("clock");
    wr(A_WAK, 32'h01);
    wr(A_MOD, 32'h01);
    n0 = n_wclr;
    halt();
    chk({29'h0, cpu_halted, sysclk_run, timebase_run}, 32'h4);
    chk(n_wclr - n0, 32'h1);
    rd(A_STA, 32'h3f, 32'h1d);
    porta_in[1] <= 1'h0;
    step(4);
    chk({31'h0, cpu_halted}, 32'h1);
    porta_in[0] <= 1'h0;
    step(3);
    chk({31'h0, cpu_halted}, 32'h0);
    rd(A_STA, 32'hff, 32'h4d);
    porta_in <= 8'hff;
    end_test("sleep");
    wr(A_MOD, 32'h03);
    irq_enable <= 8'h04;
    halt();
    chk({30'h0, sysclk_run, timebase_run}, 32'h1);
    n0 = n_irq;
    irq_req <= 8'h04;
    step(4);
    chk({31'h0, cpu_halted}, 32'h0);
    chk(n_irq - n0, 32'h1);
    irq_req <= 8'h0;
    rd(A_STA, 32'hf0, 32'h80);
    end_test("idle_off");
    stack_full <= 1'h1;
    halt();
    n0 = n_irq;
    irq_req <= 8'h04;
    step(4);
    chk({31'h0, cpu_halted}, 32'h0);
    chk(n_irq - n0, 32'h0);
    irq_req <= 8'h0;
    stack_full <= 1'h0;
    end_test("stack_full");
    wr(A_CTL, 32'h80);
    irq_req <= 8'h08;
    irq_enable <= 8'h08;
    halt();
    chk({30'h0, cpu_halted, sysclk_run}, 32'h3);
    step(6);
    chk({31'h0, cpu_halted}, 32'h1);
    n0 = n_prst;
    wdt_overflow <= 1'h1;
    step(1);
    wdt_overflow <= 1'h0;
    step(3);
    chk({31'h0, cpu_halted}, 32'h0);
    chk(n_prst - n0, 32'h1);
    rd(A_STA, 32'hff, 32'hcf);
    irq_req <= 8'h0;
    clrwdt_exec <= 1'h1;
    step(1);
    clrwdt_exec <= 1'h0;
    step(2);
    rd(A_STA, 32'h01, 32'h0);
    end_test("idle_on");
    print_verdict();
  end
endmodule
`default_nettype wire
